// ### egc_regs.sv
// APB register bank of the event generator: status, control, interrupt flags and enables
//
// Register access over APB was chosen for this implementation.
module egc_regs #(
  parameter int BEACON_INTERVAL_CYC = egc_pkg::BEACON_INTERVAL_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [egc_pkg::ADDR_W-1:0] paddr,
  input wire logic [egc_pkg::DATA_W-1:0] pwdata,
  output logic [egc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rxDbus,
  input wire logic [7:0] txDbus,
  input wire logic [1:0] seqRollover,
  input wire logic [1:0] seqHalfway,
  input wire logic [1:0] seqStop,
  input wire logic [1:0] seqStart,
  input wire logic externalEvent,
  input wire logic dataBufferEvent,
  input wire logic rxFifoFull,
  input wire logic rxViolation,
  output logic generatorMasterEnable,
  output logic receptionDisable,
  output logic receiverPowerDown,
  output logic rxFifoReset,
  output logic softReset,
  output logic littleEndianSelect,
  output logic muxCounterReset,
  output logic beaconEnable,
  output logic systemMasterEnable,
  output logic beaconValid,
  output logic [7:0] beaconCode,
  output logic irqRequest
);

  typedef struct packed {
    egc_pkg::egc_apb_state_t apbState;
    logic [31:0] control;
    logic [31:0] enables;
    logic [31:0] rdata;
    logic slvErr;
    logic fifoResetPulse;
    logic softResetPulse;
    logic muxResetPulse;
    logic fifoFullPrev;
    logic irq;
  } egc_regs_state_t;

  egc_regs_state_t state_reg;
  egc_regs_state_t state_next;

  logic [31:0] flags;
  logic [31:0] flagSet;
  logic [31:0] flagClr;
  logic [31:0] statusWord;
  logic setupPhase;
  logic accessPhase;
  logic writeAccess;

  function automatic logic regHit(
    input logic [egc_pkg::ADDR_W-1:0] addr,
    input logic [11:0] offset
  );
    regHit = (addr == offset);
  endfunction

  function automatic logic mapped(input logic [egc_pkg::ADDR_W-1:0] addr);
    mapped = regHit(addr, egc_pkg::STATUS_OFFSET) || regHit(addr, egc_pkg::CONTROL_OFFSET) ||
             regHit(addr, egc_pkg::FLAGS_OFFSET) || regHit(addr, egc_pkg::ENABLES_OFFSET);
  endfunction

  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable && (state_reg.apbState == egc_pkg::APB_ACCESS);
  assign writeAccess = accessPhase && pwrite && mapped(paddr);

  // Live bus bits, read through the status word
  always_comb begin
    statusWord = '0;
    statusWord[egc_pkg::RX_DBUS_LSB +: 8] = rxDbus;
    statusWord[egc_pkg::TX_DBUS_LSB +: 8] = txDbus;
  end

  // Map each hardware event onto its flag position
  always_comb begin
    flagSet = '0;
    flagSet[egc_pkg::SEQ1_ROLLOVER_BIT] = seqRollover[1];
    flagSet[egc_pkg::SEQ0_ROLLOVER_BIT] = seqRollover[0];
    flagSet[egc_pkg::SEQ1_HALFWAY_BIT] = seqHalfway[1];
    flagSet[egc_pkg::SEQ0_HALFWAY_BIT] = seqHalfway[0];
    flagSet[egc_pkg::SEQ1_STOP_BIT] = seqStop[1];
    flagSet[egc_pkg::SEQ0_STOP_BIT] = seqStop[0];
    flagSet[egc_pkg::SEQ1_START_BIT] = seqStart[1];
    flagSet[egc_pkg::SEQ0_START_BIT] = seqStart[0];
    flagSet[egc_pkg::EXTERNAL_IRQ_BIT] = externalEvent;
    flagSet[egc_pkg::DATA_BUFFER_BIT] = dataBufferEvent;
    // Full is a level; only its rising edge raises the flag
    flagSet[egc_pkg::RX_FIFO_FULL_BIT] = rxFifoFull && !state_reg.fifoFullPrev;
    flagSet[egc_pkg::RX_VIOLATION_BIT] = rxViolation;
  end

  always_comb begin
    flagClr = '0;
    if (writeAccess && regHit(paddr, egc_pkg::FLAGS_OFFSET)) begin
      flagClr = pwdata;
    end
  end

  egc_w1c_flags #(
    .WIDTH(32),
    .MASK(egc_pkg::FLAG_MASK)
  ) u_flags (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .setVec(flagSet),
    .clrVec(flagClr),
    .clearAll(state_reg.softResetPulse),
    .flags(flags)
  );

  egc_beacon_gen #(
    .INTERVAL_CYC(BEACON_INTERVAL_CYC),
    .CNT_W(16)
  ) u_beacon (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .enable(generatorMasterEnable && beaconEnable),
    .beaconValid(beaconValid),
    .beaconCode(beaconCode)
  );

  always_comb begin
    state_next = state_reg;
    state_next.fifoResetPulse = 1'b0;
    state_next.softResetPulse = 1'b0;
    state_next.muxResetPulse = 1'b0;
    state_next.fifoFullPrev = rxFifoFull;

    case (state_reg.apbState)
      egc_pkg::APB_IDLE: begin
        if (setupPhase) begin
          // Read data is captured at the end of setup, ready in the access cycle
          state_next.apbState = egc_pkg::APB_ACCESS;
          state_next.slvErr = !mapped(paddr);
          state_next.rdata = '0;
          if (!pwrite) begin
            if (regHit(paddr, egc_pkg::STATUS_OFFSET)) begin
              state_next.rdata = statusWord;
            end else if (regHit(paddr, egc_pkg::CONTROL_OFFSET)) begin
              state_next.rdata = state_reg.control;
            end else if (regHit(paddr, egc_pkg::FLAGS_OFFSET)) begin
              state_next.rdata = flags;
            end else if (regHit(paddr, egc_pkg::ENABLES_OFFSET)) begin
              state_next.rdata = state_reg.enables;
            end
          end
        end
      end
      egc_pkg::APB_ACCESS: begin
        if (!(psel && penable)) begin
          state_next.apbState = egc_pkg::APB_IDLE;
        end else begin
          state_next.apbState = egc_pkg::APB_IDLE;
          if (writeAccess && regHit(paddr, egc_pkg::CONTROL_OFFSET)) begin
            // Command bits are never stored, so they always read back zero
            state_next.control = pwdata & egc_pkg::CONTROL_STORED_MASK;
            state_next.muxResetPulse = pwdata[egc_pkg::MUX_COUNTER_RESET_BIT];
            state_next.fifoResetPulse = pwdata[egc_pkg::RX_FIFO_RESET_BIT];
            state_next.softResetPulse = pwdata[egc_pkg::SOFT_RESET_BIT];
          end
          if (writeAccess && regHit(paddr, egc_pkg::ENABLES_OFFSET)) begin
            state_next.enables = pwdata & egc_pkg::ENABLE_MASK;
          end
        end
      end
      default: begin
        state_next.apbState = egc_pkg::APB_IDLE;
      end
    endcase

    // Request is registered: one cycle from flag or enable change to the pin
    state_next.irq = state_reg.enables[egc_pkg::MASTER_IRQ_EN_BIT] &&
                     state_reg.enables[egc_pkg::HOST_BUS_IRQ_EN_BIT] &&
                     |(flags & state_reg.enables & egc_pkg::FLAG_MASK);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg.apbState <= egc_pkg::APB_IDLE;
      state_reg.control <= egc_pkg::CONTROL_RESET;
      state_reg.enables <= egc_pkg::ENABLES_RESET;
      state_reg.rdata <= '0;
      state_reg.slvErr <= 1'b0;
      state_reg.fifoResetPulse <= 1'b0;
      state_reg.softResetPulse <= 1'b0;
      state_reg.muxResetPulse <= 1'b0;
      state_reg.fifoFullPrev <= 1'b0;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pready = accessPhase;
  assign prdata = state_reg.rdata;
  assign pslverr = accessPhase && state_reg.slvErr;

  assign generatorMasterEnable = state_reg.control[egc_pkg::GEN_MASTER_EN_BIT];
  assign receptionDisable = state_reg.control[egc_pkg::RX_DISABLE_BIT];
  assign receiverPowerDown = state_reg.control[egc_pkg::RX_POWER_DOWN_BIT];
  assign littleEndianSelect = state_reg.control[egc_pkg::LITTLE_ENDIAN_BIT];
  assign beaconEnable = state_reg.control[egc_pkg::BEACON_EN_BIT];
  assign systemMasterEnable = state_reg.control[egc_pkg::SYS_MASTER_EN_BIT];
  assign rxFifoReset = state_reg.fifoResetPulse;
  assign softReset = state_reg.softResetPulse;
  assign muxCounterReset = state_reg.muxResetPulse;
  assign irqRequest = state_reg.irq;

endmodule

// ### egc_pkg.sv
// Shared offsets, field positions, reset values and timing for the event generator register bank
package egc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] STATUS_OFFSET = 12'h000;
  localparam logic [11:0] CONTROL_OFFSET = 12'h004;
  localparam logic [11:0] FLAGS_OFFSET = 12'h008;
  localparam logic [11:0] ENABLES_OFFSET = 12'h00C;

  // Status word fields
  localparam int RX_DBUS_LSB = 24;
  localparam int TX_DBUS_LSB = 16;

  // Control word fields
  localparam int GEN_MASTER_EN_BIT = 31;
  localparam int RX_DISABLE_BIT = 30;
  localparam int RX_POWER_DOWN_BIT = 29;
  localparam int RX_FIFO_RESET_BIT = 28;
  localparam int SOFT_RESET_BIT = 26;
  localparam int LITTLE_ENDIAN_BIT = 25;
  localparam int MUX_COUNTER_RESET_BIT = 24;
  localparam int BEACON_EN_BIT = 23;
  localparam int SYS_MASTER_EN_BIT = 22;
  localparam logic [31:0] CONTROL_STORED_MASK = 32'hE2C0_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  // Flag word and enable word share these positions
  localparam int SEQ1_ROLLOVER_BIT = 21;
  localparam int SEQ0_ROLLOVER_BIT = 20;
  localparam int SEQ1_HALFWAY_BIT = 17;
  localparam int SEQ0_HALFWAY_BIT = 16;
  localparam int SEQ1_STOP_BIT = 13;
  localparam int SEQ0_STOP_BIT = 12;
  localparam int SEQ1_START_BIT = 9;
  localparam int SEQ0_START_BIT = 8;
  localparam int EXTERNAL_IRQ_BIT = 6;
  localparam int DATA_BUFFER_BIT = 5;
  localparam int RX_FIFO_FULL_BIT = 1;
  localparam int RX_VIOLATION_BIT = 0;
  localparam logic [31:0] FLAG_MASK = 32'h0033_3363;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

  // Enable word top bits
  localparam int MASTER_IRQ_EN_BIT = 31;
  localparam int HOST_BUS_IRQ_EN_BIT = 30;
  localparam logic [31:0] ENABLE_MASK = 32'hC033_3363;
  localparam logic [31:0] ENABLES_RESET = 32'h0000_0000;

  // Beacon
  localparam logic [7:0] BEACON_CODE = 8'h7E;
  localparam logic [7:0] NO_CODE = 8'h00;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BEACON_INTERVAL_NS = 1000;
  localparam int BEACON_INTERVAL_CYC = (BEACON_INTERVAL_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic {
    APB_IDLE,
    APB_ACCESS
  } egc_apb_state_t;

endpackage

// ### egc_w1c_flags.sv
// Sticky event flags, cleared by writing one, with a set that beats a clear
module egc_w1c_flags #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] MASK = '1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] setVec,
  input wire logic [WIDTH-1:0] clrVec,
  input wire logic clearAll,
  output logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } egc_w1c_state_t;

  egc_w1c_state_t state_reg;
  egc_w1c_state_t state_next;

  always_comb begin
    state_next = state_reg;
    // Set is applied last so an event in the clearing cycle survives
    state_next.flags = (state_reg.flags & ~clrVec & ~{WIDTH{clearAll}}) | setVec;
    state_next.flags = state_next.flags & MASK;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags = state_reg.flags;

endmodule

// ### egc_beacon_gen.sv
// Periodic delay-compensation beacon request generator
module egc_beacon_gen #(
  parameter int INTERVAL_CYC = egc_pkg::BEACON_INTERVAL_CYC,
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic enable,
  output logic beaconValid,
  output logic [7:0] beaconCode
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic valid;
    logic [7:0] code;
  } egc_beacon_state_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(INTERVAL_CYC - 1);

  egc_beacon_state_t state_reg;
  egc_beacon_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.valid = 1'b0;
    state_next.code = egc_pkg::NO_CODE;
    if (!enable) begin
      // Restart the interval so the first beacon comes a full period after enabling
      state_next.count = '0;
    end else if (state_reg.count == LAST) begin
      state_next.count = '0;
      state_next.valid = 1'b1;
      state_next.code = egc_pkg::BEACON_CODE;
    end else begin
      state_next.count = state_reg.count + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign beaconValid = state_reg.valid;
  assign beaconCode = state_reg.code;

endmodule

// ### egc_regs_checker.sv
// Port-level assertions for the event generator register bank
module egc_regs_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [egc_pkg::ADDR_W-1:0] paddr,
  input wire logic [egc_pkg::DATA_W-1:0] pwdata,
  input wire logic [egc_pkg::DATA_W-1:0] prdata,
  input wire logic [7:0] rxDbus,
  input wire logic [7:0] txDbus,
  input wire logic generatorMasterEnable,
  input wire logic littleEndianSelect,
  input wire logic muxCounterReset,
  input wire logic beaconEnable,
  input wire logic beaconValid,
  input wire logic [7:0] beaconCode,
  input wire logic irqRequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic ctlWr;
  logic enWr;
  logic stRd;
  assign ctlWr = psel && penable && pwrite && paddr == 12'h004;
  assign enWr = psel && penable && pwrite && paddr == 12'h00C;
  assign stRd = psel && !penable && !pwrite && paddr == 12'h000;
  a_rx_status_byte: assert property (stRd |=> prdata[31:24] == $past(rxDbus))
    else $error("received bus byte not in status bits 31..24");
  a_tx_status_byte: assert property (stRd |=> prdata[23:16] == $past(txDbus))
    else $error("transmitted bus byte not in status bits 23..16");
  a_master_en_write: assert property (ctlWr |=> generatorMasterEnable == $past(pwdata[31]))
    else $error("master enable does not follow control bit 31");
  a_cnt_reset_pulse: assert property (ctlWr && pwdata[24] |=> muxCounterReset ##1 !muxCounterReset)
    else $error("counter reset is not a one-cycle pulse");
  a_endian_write: assert property (ctlWr |=> littleEndianSelect == $past(pwdata[25]))
    else $error("byte order select does not follow control bit 25");
  a_beacon_code: assert property (beaconValid |-> beaconCode == 8'h7E)
    else $error("beacon carries a wrong code");
  a_beacon_off: assert property (!beaconEnable |=> !beaconValid)
    else $error("beacon sent while beacon enable is clear");
  a_irq_top_gate: assert property (enWr && pwdata[31:30] != 2'b11 |=> ##1 !irqRequest)
    else $error("interrupt with a top enable clear");
  cover property (ctlWr && pwdata[24]);
  cover property (beaconValid);
  cover property (irqRequest);
endmodule

bind egc_regs egc_regs_checker chk_i (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .rxDbus, .txDbus, .generatorMasterEnable, .littleEndianSelect,
  .muxCounterReset, .beaconEnable, .beaconValid, .beaconCode, .irqRequest);

// ### egc_apb_host.sv
// APB host model issuing single transfers to the register bank
module egc_apb_host (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end
  // Request held until pready is seen at a rising edge, for at most 20 edges; no latency assumed
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    hung = pready !== 1'b1;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### tb_egc_regs.sv
// Self-checking bench for the event generator register bank
module tb_egc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} egc_row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] rxDbus = 8'hA5;
  logic [7:0] txDbus = 8'h3C;
  logic [1:0] seqRollover = 2'h0, seqHalfway = 2'h0, seqStop = 2'h0, seqStart = 2'h0;
  logic externalEvent = 1'b0, dataBufferEvent = 1'b0, rxFifoFull = 1'b0, rxViolation = 1'b0;
  logic generatorMasterEnable, beaconValid, irqRequest;
  logic [7:0] beaconCode;
  int err_count = 0;
  int n_tests = 0;
  egc_row_t rows[3];
  egc_regs #(.BEACON_INTERVAL_CYC(4)) egc_regs_i (.sys_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rxDbus, .txDbus, .seqRollover, .seqHalfway,
    .seqStop, .seqStart, .externalEvent, .dataBufferEvent, .rxFifoFull, .rxViolation,
    .generatorMasterEnable, .receptionDisable(), .receiverPowerDown(), .rxFifoReset(),
    .softReset(), .littleEndianSelect(), .muxCounterReset(), .beaconEnable(),
    .systemMasterEnable(), .beaconValid, .beaconCode, .irqRequest);
  egc_apb_host egc_apb_host_i (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Counts: %0d checks, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] d);
    egc_apb_host_i.xfer(wr, a, d, q, err);
    if (egc_apb_host_i.hung) begin
      err_count++;
      $display("CHECK FAILED at %0t: bus hung", $time);
      stop_test();
    end
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(negedge sys_clk);
    chk({31'h0, irqRequest}, {31'h0, v}, "interrupt request");
  endtask
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    // Master node: beacon and system-master bits are ours to set
    rows[0] = '{12'h004, 32'hFFFF_FFFF, 32'hE2C0_0000};
    rows[1] = '{12'h00C, 32'hFFFF_FFFF, 32'hC033_3363};
    rows[2] = '{12'h000, 32'hFFFF_FFFF, 32'hA53C_0000};
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      rw(1'b0, 12'(4 * i), 32'h0);
      chk(q, 32'h0, "reset value");
    end
    foreach (rows[i]) begin
      rw(1'b1, rows[i].a, rows[i].w);
      rw(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].e, "readback");
      $display("row %0d done", i);
    end
    for (int n = 0; n < 20 && beaconValid !== 1'b1; n++) @(negedge sys_clk);
    chk({23'h0, generatorMasterEnable, beaconCode}, 32'h17E, "beacon");
    rw(1'b1, 12'h004, 32'h8000_0000);
    // A beacon launched at the write edge itself was still legal; look from the next edge on
    @(posedge sys_clk);
    repeat (8) begin
      @(negedge sys_clk);
      chk({31'h0, beaconValid}, 32'h0, "beacon off");
    end
    $display("beacon test done");
    @(posedge sys_clk);
    {seqRollover, seqHalfway, seqStop, seqStart} <= 8'hFF;
    {externalEvent, dataBufferEvent, rxFifoFull, rxViolation} <= 4'hF;
    @(posedge sys_clk);
    {seqRollover, seqHalfway, seqStop, seqStart} <= 8'h00;
    {externalEvent, dataBufferEvent, rxViolation} <= 3'h0;
    rw(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0033_3363, "flags set");
    irq_is(1'b1);
    rw(1'b1, 12'h00C, 32'h8033_3363);
    irq_is(1'b0);
    rw(1'b1, 12'h008, 32'h0);
    rw(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0033_3363, "zero write keeps flags");
    // Fifo-full level stays high: only its rising edge may set the flag
    rw(1'b1, 12'h008, 32'h0000_0003);
    rw(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0033_3360, "one write clears");
    rw(1'b1, 12'h00C, 32'hC000_0003);
    irq_is(1'b0);
    @(posedge sys_clk);
    rxViolation <= 1'b1;
    @(posedge sys_clk);
    rxViolation <= 1'b0;
    irq_is(1'b1);
    $display("interrupt test done");
    rw(1'b0, 12'h010, 32'h0);
    chk(q | {31'h0, err}, 32'h1, "unmapped read");
    @(posedge sys_clk);
    rxDbus <= 8'h80;
    txDbus <= 8'h01;
    rw(1'b0, 12'h000, 32'h0);
    chk(q, 32'h8001_0000, "status bit order");
    $display("status test done");
    stop_test();
  end
endmodule
